// [ppc_map.svh]
/*
  register offsets, field positions, reset values and drive-mode codes
  of the port pin control block.
  assumes the includer uses an 8-bit byte offset within the block.
*/
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH
`define PPC_NPIN 8
`define PPC_NOE 16
`define PPC_NPAIR 4
`define PPC_NPLANE 8
`define PPC_OFF_OUT 8'h00
`define PPC_OFF_STATE 8'h04
`define PPC_OFF_DM0 8'h08
`define PPC_OFF_DM1 8'h0C
`define PPC_OFF_DM2 8'h10
`define PPC_OFF_SLEW 8'h14
`define PPC_OFF_BIDIR 8'h18
`define PPC_OFF_BYPASS 8'h1C
`define PPC_OFF_INDIS 8'h20
`define PPC_OFF_RISE 8'h24
`define PPC_OFF_FALL 8'h28
`define PPC_OFF_ISTAT 8'h2C
`define PPC_OFF_CFG 8'h30
`define PPC_OFF_VREG 8'h34
`define PPC_OFF_REF 8'h38
`define PPC_OFF_OESEL 8'h3C
`define PPC_PIN_BASE 8'h40
`define PPC_PIN_MASK 8'hE3
`define PPC_PL_OUT 0
`define PPC_PL_DM0 1
`define PPC_PL_DM1 2
`define PPC_PL_DM2 3
`define PPC_PL_SLEW 4
`define PPC_PL_BIDIR 5
`define PPC_PL_BYPASS 6
`define PPC_PL_INDIS 7
`define PPC_CFG_LVTTL 0
`define PPC_CFG_HYST 1
`define PPC_CFG_DIFF 2
`define PPC_CFG_W 3
`define PPC_REF_W 16
`define PPC_RST_BYTE 8'h00
`define PPC_RST_CFG 3'h0
`define PPC_RST_REF 16'h0000
`define PPC_RST_OESEL 32'h0000_0000
`define PPC_DM_ANA_HIZ 3'h0
`define PPC_DM_DIG_HIZ 3'h1
`define PPC_DM_PULL_UP 3'h2
`define PPC_DM_PULL_DN 3'h3
`define PPC_DM_OD_LOW 3'h4
`define PPC_DM_OD_HIGH 3'h5
`define PPC_DM_STRONG 3'h6
`define PPC_DM_RES_BOTH 3'h7
`endif

// [ppc_pads.sv]
/* far-side pad model: resolves each pin level from the port's drive
   and an external driver. assumes pins are sampled on pclk. */
`timescale 1ns/10ps
`default_nettype none
`include "ppc_map.svh"
module ppc_pads (
  // clock
  input wire logic pclk,
  // device drive
  input wire logic [`PPC_NPIN-1:0] pin_out,
  input wire logic [`PPC_NPIN-1:0] pin_oe,
  input wire logic [`PPC_NPIN-1:0] pin_pu_en,
  input wire logic [`PPC_NPIN-1:0] pin_pd_en,
  // external driver
  input wire logic ext_en,
  input wire logic [`PPC_NPIN-1:0] ext_val,
  // resolved level
  output logic [`PPC_NPIN-1:0] pin_level
);
  logic [`PPC_NPIN-1:0] last_q = '0; // known start, never unknown
  // floating pins toggle so a stale level never looks valid
  always_comb begin
    for (int i = 0; i < `PPC_NPIN; i++) begin
      if (pin_oe[i]) begin
        pin_level[i] = pin_out[i];
      end else if (ext_en) begin
        pin_level[i] = ext_val[i];
      end else if (pin_pu_en[i] || pin_pd_en[i]) begin
        pin_level[i] = pin_pu_en[i];
      end else begin
        pin_level[i] = ~last_q[i];
      end
    end
  end
  always_ff @(posedge pclk) begin
    last_q <= pin_level;
  end
endmodule
`default_nettype wire

// [ppc_pkg.sv]
/*
  types of the port pin control block.
  assumes ppc_map.svh is compiled alongside.
*/
package ppc_pkg;
  typedef logic [2:0] ppc_mode_t;
  typedef struct packed {
    logic oe;
    logic out;
    logic pu;
    logic pd;
    logic fast;
    logic inbuf;
  } ppc_drive_s;
endpackage

// [ppc_port.sv]
/*
  eight-pin port pin control: drive modes, port and pin register views,
  bidirectional steering, slew, edge interrupts and special pin settings.
  assumes an apb master on pclk and pin inputs synchronous to pclk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ppc_map.svh"
module ppc_port
  import ppc_pkg::*;
#(
  parameter int AW = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pads
  input wire logic [`PPC_NPIN-1:0] pin_in,
  output logic [`PPC_NPIN-1:0] pin_out,
  output logic [`PPC_NPIN-1:0] pin_oe,
  output logic [`PPC_NPIN-1:0] pin_pu_en,
  output logic [`PPC_NPIN-1:0] pin_pd_en,
  output logic [`PPC_NPIN-1:0] pin_slew_fast,
  output logic [`PPC_NPIN-1:0] pin_inbuf_en,
  // digital system side
  input wire logic [`PPC_NPIN-1:0] sys_out,
  input wire logic [`PPC_NOE-1:0] aux_oe,
  output logic [`PPC_NPIN-1:0] sys_in,
  output logic irq,
  // special pin controls
  output logic lvttl_sel,
  output logic sio_hyst_en,
  output logic sio_diff_en,
  output logic [`PPC_NPIN-1:0] sio_vreg_sel,
  output logic [2*`PPC_NPAIR-1:0] sio_thresh_sel,
  output logic [`PPC_NPAIR-1:0] sio_ag_sel
);

  localparam int OESW = $clog2(`PPC_NOE);

  logic [`PPC_NPIN-1:0] plane_q [`PPC_NPLANE];
  logic [`PPC_NPIN-1:0] rise_q;
  logic [`PPC_NPIN-1:0] fall_q;
  logic [`PPC_NPIN-1:0] stat_q;
  logic [`PPC_NPIN-1:0] vreg_q;
  logic [`PPC_CFG_W-1:0] cfg_q;
  logic [`PPC_REF_W-1:0] ref_q;
  logic [31:0] oesel_q;
  logic [`PPC_NPIN-1:0] ps_q;
  logic [`PPC_NPIN-1:0] prev_q;
  logic [31:0] rdata_q;
  logic err_q;
  logic irq_q;
  ppc_drive_s drv_q [`PPC_NPIN];

  logic [7:0] addr;
  logic upper_zero;
  logic setup;
  logic access;
  logic wr;
  logic rd_istat;
  logic pin_hit;
  logic [2:0] pin_idx;
  logic [31:0] rd_d;
  logic hit_d;
  logic [`PPC_NPIN-1:0] ev;
  logic [`PPC_NPIN-1:0] clr;

  function automatic logic [7:0] plane_addr(input int k);
    logic [7:0] a;
    a = `PPC_OFF_OUT;
    case (k)
      `PPC_PL_DM0: a = `PPC_OFF_DM0;
      `PPC_PL_DM1: a = `PPC_OFF_DM1;
      `PPC_PL_DM2: a = `PPC_OFF_DM2;
      `PPC_PL_SLEW: a = `PPC_OFF_SLEW;
      `PPC_PL_BIDIR: a = `PPC_OFF_BIDIR;
      `PPC_PL_BYPASS: a = `PPC_OFF_BYPASS;
      `PPC_PL_INDIS: a = `PPC_OFF_INDIS;
      default: a = `PPC_OFF_OUT;
    endcase
    return a;
  endfunction

  function automatic ppc_drive_s drive_decode(
    input ppc_mode_t mode,
    input logic data,
    input logic slow_n,
    input logic in_dis
  );
    ppc_drive_s d;
    d = '0;
    d.out = data;
    case (mode)
      `PPC_DM_ANA_HIZ: begin
        d.inbuf = 1'b0;
      end
      `PPC_DM_DIG_HIZ: begin
        d.inbuf = 1'b1;
      end
      `PPC_DM_PULL_UP: begin
        d.pu = data;
        d.oe = ~data;
        d.inbuf = 1'b1;
      end
      `PPC_DM_PULL_DN: begin
        d.pd = ~data;
        d.oe = data;
        d.inbuf = 1'b1;
      end
      `PPC_DM_OD_LOW: begin
        d.oe = ~data;
        d.fast = slow_n;
        d.inbuf = 1'b1;
      end
      `PPC_DM_OD_HIGH: begin
        d.oe = data;
        d.fast = slow_n;
        d.inbuf = 1'b1;
      end
      `PPC_DM_STRONG: begin
        d.oe = 1'b1;
        d.fast = slow_n;
        d.inbuf = 1'b1;
      end
      default: begin
        d.pu = data;
        d.pd = ~data;
        d.inbuf = 1'b1;
      end
    endcase
    if (in_dis) begin
      d.inbuf = 1'b0;
    end
    return d;
  endfunction

  // apb decode; no wait state, read data is registered in the setup phase so it leaves a flip-flop
  assign addr = paddr[7:0];
  assign upper_zero = (paddr[AW-1:8] == '0);
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite & ~err_q;
  assign pin_hit = upper_zero
    && ((addr & `PPC_PIN_MASK) == `PPC_PIN_BASE);
  assign pin_idx = addr[4:2];
  assign rd_istat = access & ~pwrite & upper_zero
    && (addr == `PPC_OFF_ISTAT);

  always_comb begin
    rd_d = '0;
    hit_d = 1'b0;
    if (!upper_zero) begin
      hit_d = 1'b0;
    end else if (pin_hit) begin
      hit_d = 1'b1;
      for (int k = 0; k < `PPC_NPLANE; k++) begin
        rd_d[k] = plane_q[k][pin_idx];
      end
    end else if (addr == `PPC_OFF_STATE) begin
      hit_d = 1'b1;
      rd_d[`PPC_NPIN-1:0] = ps_q;
    end else if (addr == `PPC_OFF_RISE) begin
      hit_d = 1'b1;
      rd_d[`PPC_NPIN-1:0] = rise_q;
    end else if (addr == `PPC_OFF_FALL) begin
      hit_d = 1'b1;
      rd_d[`PPC_NPIN-1:0] = fall_q;
    end else if (addr == `PPC_OFF_ISTAT) begin
      hit_d = 1'b1;
      rd_d[`PPC_NPIN-1:0] = stat_q;
    end else if (addr == `PPC_OFF_CFG) begin
      hit_d = 1'b1;
      rd_d[`PPC_CFG_W-1:0] = cfg_q;
    end else if (addr == `PPC_OFF_VREG) begin
      hit_d = 1'b1;
      rd_d[`PPC_NPIN-1:0] = vreg_q;
    end else if (addr == `PPC_OFF_REF) begin
      hit_d = 1'b1;
      rd_d[`PPC_REF_W-1:0] = ref_q;
    end else if (addr == `PPC_OFF_OESEL) begin
      hit_d = 1'b1;
      rd_d = oesel_q;
    end else begin
      for (int k = 0; k < `PPC_NPLANE; k++) begin
        if (addr == plane_addr(k)) begin
          hit_d = 1'b1;
          rd_d[`PPC_NPIN-1:0] = plane_q[k];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
      err_q <= 1'b0;
    end else if (setup) begin
      rdata_q <= pwrite ? 32'h0000_0000 : rd_d;
      err_q <= ~hit_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = access;
  assign pslverr = access & err_q;

  // both views write the same bit planes; a pin write touches one column
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < `PPC_NPLANE; k++) begin
        plane_q[k] <= `PPC_RST_BYTE;
      end
    end else if (wr) begin
      for (int k = 0; k < `PPC_NPLANE; k++) begin
        if (pin_hit) begin
          plane_q[k][pin_idx] <= pwdata[k];
        end else if (upper_zero && addr == plane_addr(k)) begin
          plane_q[k] <= pwdata[`PPC_NPIN-1:0];
        end
      end
    end
  end

  // interrupt type and special pin configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_q <= `PPC_RST_BYTE;
      fall_q <= `PPC_RST_BYTE;
    end else if (wr && upper_zero) begin
      if (addr == `PPC_OFF_RISE) begin
        rise_q <= pwdata[`PPC_NPIN-1:0];
      end
      if (addr == `PPC_OFF_FALL) begin
        fall_q <= pwdata[`PPC_NPIN-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `PPC_RST_CFG;
      vreg_q <= `PPC_RST_BYTE;
      ref_q <= `PPC_RST_REF;
    end else if (wr && upper_zero) begin
      if (addr == `PPC_OFF_CFG) begin
        cfg_q <= pwdata[`PPC_CFG_W-1:0];
      end
      if (addr == `PPC_OFF_VREG) begin
        vreg_q <= pwdata[`PPC_NPIN-1:0];
      end
      if (addr == `PPC_OFF_REF) begin
        ref_q <= pwdata[`PPC_REF_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oesel_q <= `PPC_RST_OESEL;
    end else if (wr && upper_zero && addr == `PPC_OFF_OESEL) begin
      oesel_q <= pwdata;
    end
  end

  // pad drive, registered so pads never see decode glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `PPC_NPIN; i++) begin
        drv_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < `PPC_NPIN; i++) begin
        logic [OESW-1:0] sel;
        ppc_mode_t mode;
        logic data;
        sel = oesel_q[i*OESW +: OESW];
        mode = {plane_q[`PPC_PL_DM2][i], plane_q[`PPC_PL_DM1][i],
                plane_q[`PPC_PL_DM0][i]};
        if (plane_q[`PPC_PL_BIDIR][i] && !aux_oe[sel]) begin
          mode = `PPC_DM_DIG_HIZ;
        end
        data = plane_q[`PPC_PL_BYPASS][i] ? sys_out[i]
                                          : plane_q[`PPC_PL_OUT][i];
        drv_q[i] <= drive_decode(mode, data, plane_q[`PPC_PL_SLEW][i],
                                 plane_q[`PPC_PL_INDIS][i]);
      end
    end
  end

  always_comb begin
    for (int i = 0; i < `PPC_NPIN; i++) begin
      pin_out[i] = drv_q[i].out;
      pin_oe[i] = drv_q[i].oe;
      pin_pu_en[i] = drv_q[i].pu;
      pin_pd_en[i] = drv_q[i].pd;
      pin_slew_fast[i] = drv_q[i].fast;
      pin_inbuf_en[i] = drv_q[i].inbuf;
    end
  end

  // input sampling; a disabled buffer reads low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_q <= `PPC_RST_BYTE;
      prev_q <= `PPC_RST_BYTE;
    end else begin
      ps_q <= pin_in & pin_inbuf_en;
      prev_q <= ps_q;
    end
  end

  assign sys_in = ps_q;

  // edges only; enabling a buffer on a high pin looks like a rising edge
  assign ev = (ps_q & ~prev_q & rise_q)
            | (~ps_q & prev_q & fall_q);
  assign clr = rd_istat ? rdata_q[`PPC_NPIN-1:0] : `PPC_RST_BYTE;

  // no sleep gating here, so detection runs in every power state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= `PPC_RST_BYTE;
    end else begin
      stat_q <= (stat_q & ~clr) | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |((stat_q & ~clr) | ev);
    end
  end

  assign irq = irq_q;

  // special pin controls straight from their registers
  assign lvttl_sel = cfg_q[`PPC_CFG_LVTTL];
  assign sio_hyst_en = cfg_q[`PPC_CFG_HYST];
  assign sio_diff_en = cfg_q[`PPC_CFG_DIFF];
  assign sio_vreg_sel = vreg_q;

  always_comb begin
    for (int p = 0; p < `PPC_NPAIR; p++) begin
      sio_thresh_sel[2*p +: 2] = ref_q[4*p +: 2];
      sio_ag_sel[p] = ref_q[4*p+2];
    end
  end

endmodule
`default_nettype wire

// [ppc_port_checker.sv]
/* port-level assertions for the port pin control block.
   assumes it is bound into ppc_port. */
`timescale 1ns/10ps
`default_nettype none
`include "ppc_map.svh"
module ppc_port_checker
  import ppc_pkg::*;
#(
  parameter int AW = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [`PPC_NPIN-1:0] pin_in,
  input wire logic [`PPC_NPIN-1:0] pin_oe,
  input wire logic [`PPC_NPIN-1:0] pin_pu_en,
  input wire logic [`PPC_NPIN-1:0] pin_pd_en,
  input wire logic [`PPC_NPIN-1:0] pin_slew_fast,
  input wire logic [`PPC_NPIN-1:0] pin_inbuf_en,
  input wire logic [`PPC_NPIN-1:0] sys_in,
  input wire logic irq,
  input wire logic lvttl_sel,
  input wire logic sio_hyst_en,
  input wire logic sio_diff_en,
  input wire logic [`PPC_NPIN-1:0] sio_vreg_sel,
  input wire logic [2*`PPC_NPAIR-1:0] sio_thresh_sel,
  input wire logic [`PPC_NPAIR-1:0] sio_ag_sel
);
  logic wr_acc;
  logic rd_stat;
  assign wr_acc = psel && penable && pwrite;
  assign rd_stat = psel && penable && !pwrite &&
    (paddr[7:0] == `PPC_OFF_ISTAT) && (paddr[AW-1:8] == '0);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_sys_step;
    $past(sys_in) != $past(sys_in, 2);
  endsequence
  sequence s_rd_seen;
    $past(rd_stat) || $past(rd_stat, 2);
  endsequence
  a_reset_quiet: assert property ($rose(presetn) |->
    (pin_oe | pin_inbuf_en | pin_pu_en | pin_pd_en) == '0)
    else $error("pads active after reset");
  a_pull_pair: assert property ((pin_pu_en & pin_pd_en) == '0)
    else $error("pull up and down together");
  a_slew_scope: assert property (
    (pin_slew_fast & (pin_pu_en | pin_pd_en)) == '0)
    else $error("fast slew in resistive mode");
  a_input_path: assert property (
    sys_in == $past(pin_in & pin_inbuf_en))
    else $error("input path mismatch");
  a_irq_edge: assert property ($rose(irq) |-> s_sys_step)
    else $error("irq without edge");
  a_irq_hold: assert property ($fell(irq) |-> s_rd_seen)
    else $error("irq dropped without status read");
  a_cfg_write: assert property (
    $changed({lvttl_sel, sio_hyst_en, sio_diff_en}) |->
    $past(wr_acc) || $past(wr_acc, 2))
    else $error("cfg changed without write");
  a_vreg_write: assert property ($changed(sio_vreg_sel) |->
    $past(wr_acc) || $past(wr_acc, 2))
    else $error("vreg changed without write");
  a_ref_write: assert property (
    $changed({sio_thresh_sel, sio_ag_sel}) |->
    $past(wr_acc) || $past(wr_acc, 2))
    else $error("ref changed without write");
endmodule
bind ppc_port ppc_port_checker #(.AW(AW)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pin_in(pin_in), .pin_oe(pin_oe),
  .pin_pu_en(pin_pu_en), .pin_pd_en(pin_pd_en),
  .pin_slew_fast(pin_slew_fast), .pin_inbuf_en(pin_inbuf_en),
  .sys_in(sys_in), .irq(irq), .lvttl_sel(lvttl_sel),
  .sio_hyst_en(sio_hyst_en), .sio_diff_en(sio_diff_en),
  .sio_vreg_sel(sio_vreg_sel), .sio_thresh_sel(sio_thresh_sel),
  .sio_ag_sel(sio_ag_sel));
`default_nettype wire

// [tb_port_pin_control.sv]
/* self-checking bench for ppc_port over apb with a pad model.
   assumes ppc_pads and the bound checker are compiled alongside. */
`timescale 1ns/10ps
`default_nettype none
`include "ppc_map.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  n_fail++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_port_pin_control;
  import ppc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, irq, ext_en = 1'b0, err, ind;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pu_en, pin_pd_en, sys_in;
  logic [7:0] pin_slew_fast, pin_inbuf_en, sio_vreg_sel, sio_thresh_sel;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] sys_out = 8'h00;
  logic [3:0] hi = 4'h0;
  logic [15:0] aux_oe = 16'h0000;
  logic lvttl_sel, sio_hyst_en, sio_diff_en;
  logic [3:0] sio_ag_sel;
  logic [4:0] ex, gd;
  int n_fail = 0, checked = 0;
  always #10 pclk = ~pclk;
  ppc_port #(.AW(12)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu_en(pin_pu_en),
    .pin_pd_en(pin_pd_en), .pin_slew_fast(pin_slew_fast),
    .pin_inbuf_en(pin_inbuf_en), .sys_out(sys_out), .aux_oe(aux_oe),
    .sys_in(sys_in), .irq(irq), .lvttl_sel(lvttl_sel),
    .sio_hyst_en(sio_hyst_en), .sio_diff_en(sio_diff_en),
    .sio_vreg_sel(sio_vreg_sel), .sio_thresh_sel(sio_thresh_sel),
    .sio_ag_sel(sio_ag_sel));
  ppc_pads u_pads (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pu_en(pin_pu_en), .pin_pd_en(pin_pd_en), .ext_en(ext_en),
    .ext_val(ext_val), .pin_level(pin_in));
  task close_out;
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {hi, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 40) begin
      n_fail++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(nm, e, rd)
  endtask
  // {oe, driven data, pull up, pull down, fast slew}
  function automatic logic [4:0] exp_drv(input logic [2:0] m,
                                         input logic d);
    logic [4:0] r;
    case (m)
      3'h2: r = d ? 5'h04 : 5'h10;
      3'h3: r = d ? 5'h18 : 5'h02;
      3'h4: r = d ? 5'h00 : 5'h10;
      3'h5: r = d ? 5'h18 : 5'h00;
      3'h6: r = d ? 5'h18 : 5'h10;
      3'h7: r = d ? 5'h04 : 5'h02;
      default: r = 5'h00;
    endcase
    r[0] = (m >= 3'h4) && (m <= 3'h6);
    return r;
  endfunction
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd = {pin_oe, pin_pu_en, pin_pd_en, pin_inbuf_en};
    `CHK("reset pads", 32'h0000_0000, rd)
    rchk(`PPC_OFF_DM0, 32'h0, "dm0 reset");
    for (int m = 0; m < 8; m++) begin
      for (int d = 0; d < 2; d++) begin
        ind = (m == 6) && (d == 1);
        apb(1'b1, `PPC_PIN_BASE, {24'h00_0000, ind, 3'h1, m[2:0], d[0]});
        repeat (2) @(posedge pclk);
        ex = exp_drv(m[2:0], d[0]);
        gd = {pin_oe[0], pin_out[0] & pin_oe[0], pin_pu_en[0], pin_pd_en[0],
              pin_slew_fast[0]};
        `CHK("drive", ex, gd)
        `CHK("inbuf", (m != 0) && !ind, pin_inbuf_en[0])
      end
    end
    apb(1'b1, `PPC_OFF_DM0, 32'h0000_00FF);
    apb(1'b1, `PPC_OFF_DM1, 32'h0000_00FF);
    apb(1'b1, `PPC_OFF_DM2, 32'h0000_0000);
    apb(1'b1, `PPC_OFF_OUT, 32'h0000_00AA);
    repeat (2) @(posedge pclk);
    `CHK("port oe", 8'hAA, pin_oe)
    `CHK("port pd", 8'h55, pin_pd_en)
    rchk(`PPC_PIN_BASE + 8'h04, 32'h0000_0007, "pin1 view");
    apb(1'b1, `PPC_PIN_BASE + 8'h08, 32'h0000_000D);
    rchk(`PPC_OFF_DM2, 32'h0000_0004, "dm2 plane");
    apb(1'b1, `PPC_OFF_DM0, 32'h0000_0000);
    apb(1'b1, `PPC_OFF_DM2, 32'h0000_00FF);
    apb(1'b1, `PPC_OFF_OUT, 32'h0000_00FF);
    apb(1'b1, `PPC_OFF_OESEL, 32'hF000_0005);
    apb(1'b1, `PPC_OFF_BIDIR, 32'h0000_0081);
    repeat (2) @(posedge pclk);
    `CHK("bidir off", 8'h7E, pin_oe)
    aux_oe <= 16'h8020;
    repeat (3) @(posedge pclk);
    `CHK("bidir on", 8'hFF, pin_oe)
    aux_oe <= 16'h0020;
    repeat (3) @(posedge pclk);
    `CHK("bidir mix", 8'h7F, pin_oe)
    sys_out <= 8'h05;
    apb(1'b1, `PPC_OFF_BYPASS, 32'h0000_000F);
    repeat (2) @(posedge pclk);
    `CHK("bypass", 8'hF5, pin_out)
    apb(1'b1, `PPC_OFF_CFG, 32'h0000_0003);
    apb(1'b1, `PPC_OFF_VREG, 32'h0000_00A5);
    apb(1'b1, `PPC_OFF_REF, 32'h0000_3650);
    repeat (2) @(posedge pclk);
    `CHK("cfg", 3'h6, {lvttl_sel, sio_hyst_en, sio_diff_en})
    `CHK("vreg", 8'hA5, sio_vreg_sel)
    `CHK("thresh", 8'hE4, sio_thresh_sel)
    `CHK("ag", 4'h6, sio_ag_sel)
    hi = 4'h1;
    apb(1'b1, 8'h00, 32'h0000_00FF);
    hi = 4'h0;
    `CHK("slverr", 1'b1, err)
    ext_en <= 1'b1;
    apb(1'b1, `PPC_OFF_DM0, 32'h0000_00FF);
    apb(1'b1, `PPC_OFF_DM2, 32'h0000_0000);
    apb(1'b1, `PPC_OFF_DM1, 32'h0000_0000);
    apb(1'b1, `PPC_OFF_BIDIR, 32'h0000_0000);
    apb(1'b1, `PPC_OFF_RISE, 32'h0000_0005);
    apb(1'b1, `PPC_OFF_FALL, 32'h0000_0006);
    repeat (4) @(posedge pclk);
    apb(1'b0, `PPC_OFF_ISTAT, 32'h0000_0000);
    ext_val <= 8'h0F;
    repeat (4) @(posedge pclk);
    `CHK("irq set", 1'b1, irq)
    `CHK("sys in", 8'h0F, sys_in)
    rchk(`PPC_OFF_STATE, 32'h0000_000F, "pin state");
    rchk(`PPC_OFF_ISTAT, 32'h0000_0005, "stat rise");
    @(posedge pclk);
    `CHK("irq clear", 1'b0, irq)
    rchk(`PPC_OFF_ISTAT, 32'h0000_0000, "stat empty");
    ext_val <= 8'h00;
    repeat (4) @(posedge pclk);
    rchk(`PPC_OFF_ISTAT, 32'h0000_0006, "stat fall");
    close_out();
  end
endmodule
`default_nettype wire
